// file: rtl/siasc_pkg.sv
// constants shared by the socket interrupt and status-change block
// What this block does
// - Bits 3-0 pick the card line; 0000,0001,0010,0110,1000,1101 give none.
// - Codes 3,4,5,7,9 to 12,14 and 15 pick the host line of that number.
// - Bit 4 at 0 keeps management routing, at 1 mutes all management irqs.
// - Bit 5 selects memory-only pin use at 0, I/O-and-memory use at 1.
// - Bit 6 at 0 makes card reset active, at 1 inactive; ATA inverts level.
// - Socket output enable at 0 releases card reset, whatever bit 6 holds.
// - Bit 7 with ring-out select makes battery1 ring drive line 15, I/O only.
// - A flag yields a management interrupt only while its enable bit is 1.
// - In memory mode a falling battery1 pin sets flag 0.
// - In I/O mode either edge of the battery1 pin sets flag 0.
// - In I/O mode flag 0 detection ignores control bit 7.
// - In memory mode a falling battery2 pin sets flag 1; not in I/O mode.
// - Memory mode: any ready pin edge sets flag 2; I/O mode: it reads 0.
// - Any edge on either card-detect pin sets flag 3.
// - A status read clears the flags; status bits 7 to 4 read zero.
// - An enabled set flag raises a management irq on the mgmt field line.
package siasc_pkg;

  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;
  localparam int WORD_LSB = 2;
  localparam int IDX_W    = ADDR_W - WORD_LSB;
  localparam int REG_W    = 8;
  localparam int LEVEL_W  = 4;
  localparam int IRQ_W    = 16;
  localparam int FLAG_W   = 4;
  localparam int AUX_W    = 3;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] CTRL_IDX   = 6'h03;
  localparam logic [IDX_W-1:0] STATUS_IDX = 6'h04;
  localparam logic [IDX_W-1:0] MCFG_IDX   = 6'h05;
  localparam logic [IDX_W-1:0] AUX_IDX    = 6'h08;

  localparam int CTRL_LEVEL_MSB = 3;
  localparam int CTRL_MGMT_OFF  = 4;
  localparam int CTRL_IO_MODE   = 5;
  localparam int CTRL_RESET_N   = 6;
  localparam int CTRL_RING      = 7;

  localparam int MCFG_EN_MSB    = 3;
  localparam int MCFG_LEVEL_LSB = 4;
  localparam int MCFG_LEVEL_MSB = 7;

  localparam int FLAG_BATT_DEAD = 0;
  localparam int FLAG_BATT_WARN = 1;
  localparam int FLAG_READY     = 2;
  localparam int FLAG_DETECT    = 3;

  localparam int AUX_OUT_EN   = 0;
  localparam int AUX_RING15   = 1;
  localparam int AUX_ATA      = 2;
  localparam int AUX_PIN_LSB  = 8;

  localparam int PIN_BVD1  = 0;
  localparam int PIN_BVD2  = 1;
  localparam int PIN_READY = 2;
  localparam int PIN_CD1   = 3;
  localparam int PIN_CD2   = 4;
  localparam int PIN_COUNT = 5;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [REG_W-1:0]  CTRL_RESET  = 8'h00;
  localparam logic [REG_W-1:0]  MCFG_RESET  = 8'h00;
  localparam logic [AUX_W-1:0]  AUX_RESET   = 3'h0;
  localparam logic [FLAG_W-1:0] FLAG_RESET  = 4'h0;

  // host lines 3,4,5,7,9,10,11,12,14,15
  localparam logic [IRQ_W-1:0] IRQ_VALID_MASK = 16'hDEB8;
  localparam logic [IRQ_W-1:0] IRQ_ONE        = 16'h0001;
  localparam int               IRQ_RING_LINE  = 15;

  localparam logic [1:0] SYNC_FILL_DONE = 2'h3;

endpackage

// file: rtl/siasc_route_if.sv
// carrier between the control core and the host line router
`timescale 1ns/1ps
interface siasc_route_if;
  import siasc_pkg::*;
  logic [LEVEL_W-1:0] card_level;
  logic [LEVEL_W-1:0] mgmt_level;
  logic               card_req;
  logic               mgmt_req;
  logic               ring15;
  logic [IRQ_W-1:0]   irq_lines;

  modport core (output card_level, mgmt_level, card_req, mgmt_req, ring15,
                input  irq_lines);
  modport router (input  card_level, mgmt_level, card_req, mgmt_req, ring15,
                  output irq_lines);
endinterface

// file: rtl/siasc_router.sv
// host interrupt line steering for card, management and ring sources
`timescale 1ns/1ps
module siasc_router
  import siasc_pkg::*;
(
  siasc_route_if.router bus
);

  // reserved and disabled codes fall outside the mask
  function automatic logic [IRQ_W-1:0] decode(input logic [LEVEL_W-1:0] code);
    decode = (IRQ_ONE << code) & IRQ_VALID_MASK;
  endfunction

  always_comb begin
    bus.irq_lines = '0;
    if (bus.card_req) begin
      bus.irq_lines = bus.irq_lines | decode(bus.card_level);
    end
    if (bus.mgmt_req) begin
      bus.irq_lines = bus.irq_lines | decode(bus.mgmt_level);
    end
    if (bus.ring15) begin
      bus.irq_lines[IRQ_RING_LINE] = 1'b1;
    end
  end

endmodule

// file: rtl/siasc_pin_sync.sv
// three-stage socket pin synchroniser with filtered edge pulses
`timescale 1ns/1ps
module siasc_pin_sync
  import siasc_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic [PIN_COUNT-1:0] pins,
  output logic      [PIN_COUNT-1:0] level,
  output logic      [PIN_COUNT-1:0] rise,
  output logic      [PIN_COUNT-1:0] fall
);

  typedef struct packed {
    logic [PIN_COUNT-1:0] s1;
    logic [PIN_COUNT-1:0] s2;
    logic [PIN_COUNT-1:0] s3;
    logic [PIN_COUNT-1:0] level;
    logic [PIN_COUNT-1:0] rise;
    logic [PIN_COUNT-1:0] fall;
    logic [1:0]           fill;
  } siasc_sync_state_type;

  siasc_sync_state_type s;
  siasc_sync_state_type next_s;
  logic [PIN_COUNT-1:0] agree;
  logic [PIN_COUNT-1:0] change;

  always_comb begin
    next_s = s;
    agree  = ~(s.s2 ^ s.s3);
    change = agree & (s.s3 ^ s.level);
    next_s.s1   = pins;
    next_s.s2   = s.s1;
    next_s.s3   = s.s2;
    next_s.rise = '0;
    next_s.fall = '0;
    if (s.fill != SYNC_FILL_DONE) begin
      // first settled level after reset is loaded without an edge
      next_s.fill  = s.fill + 2'h1;
      next_s.level = s.s2;
    end else begin
      next_s.level = (s.level & ~agree) | (s.s3 & agree);
      next_s.rise  = change & s.s3;
      next_s.fall  = change & ~s.s3;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign level = s.level;
  assign rise  = s.rise;
  assign fall  = s.fall;

endmodule

// file: rtl/siasc_top.sv
// socket interrupt steering, general control and status-change flags
`timescale 1ns/1ps
module siasc_top
  import siasc_pkg::*;
(
  input  wire logic              CORE_CLK,
  input  wire logic              SYS_RST,
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic              S_AXI_AWVALID,
  output logic                   S_AXI_AWREADY,
  input  wire logic [DATA_W-1:0] S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  input  wire logic              S_AXI_WVALID,
  output logic                   S_AXI_WREADY,
  output logic [1:0]             S_AXI_BRESP,
  output logic                   S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic              S_AXI_ARVALID,
  output logic                   S_AXI_ARREADY,
  output logic [DATA_W-1:0]      S_AXI_RDATA,
  output logic [1:0]             S_AXI_RRESP,
  output logic                   S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY,
  input  wire logic              CARD_READY_IRQ_PIN,
  input  wire logic              BATTERY1_STATUS_RING_PIN,
  input  wire logic              BATTERY2_SPEAKER_PIN,
  input  wire logic              CARD_DETECT_ONE,
  input  wire logic              CARD_DETECT_TWO,
  output logic [IRQ_W-1:0]       HOST_IRQ,
  output logic                   CARD_RESET_OUT,
  output logic                   CARD_RESET_OE,
  output logic                   IO_INTERFACE_MODE
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic               awready;
    logic               wready;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               aw_got;
    logic               w_got;
    logic [IDX_W-1:0]   waddr;
    logic [REG_W-1:0]   wdata;
    logic               wstb;
    logic               arready;
    logic               rvalid;
    logic [1:0]         rresp;
    logic [DATA_W-1:0]  rdata;
    logic [REG_W-1:0]   ctrl;
    logic [REG_W-1:0]   mcfg;
    logic [AUX_W-1:0]   aux;
    logic [FLAG_W-1:0]  flags;
    logic [IRQ_W-1:0]   irq;
    logic               rst_out;
    logic               rst_oe;
    logic               io_mode;
  } siasc_top_state_type;

  siasc_top_state_type  s;
  siasc_top_state_type  next_s;
  logic [PIN_COUNT-1:0] pin_raw;
  logic [PIN_COUNT-1:0] pin_level;
  logic [PIN_COUNT-1:0] pin_rise;
  logic [PIN_COUNT-1:0] pin_fall;
  logic [PIN_COUNT-1:0] pin_edge;
  logic [FLAG_W-1:0]    flag_set;
  logic [FLAG_W-1:0]    flag_vis;
  logic                 read_clear;
  logic                 io;
  logic                 card_req;
  logic                 mgmt_req;
  logic                 ring15;
  logic                 wr_fire;
  logic                 ar_fire;
  logic [IDX_W-1:0]     ar_idx;

  siasc_route_if rt ();

  // ==========================================================================
  // socket pins and router
  assign pin_raw = {CARD_DETECT_TWO, CARD_DETECT_ONE, CARD_READY_IRQ_PIN,
                    BATTERY2_SPEAKER_PIN, BATTERY1_STATUS_RING_PIN};

  siasc_pin_sync u_sync (
    .clk   (CORE_CLK),
    .rst   (SYS_RST),
    .pins  (pin_raw),
    .level (pin_level),
    .rise  (pin_rise),
    .fall  (pin_fall)
  );

  siasc_router u_router (
    .bus (rt)
  );

  assign io       = s.ctrl[CTRL_IO_MODE];
  assign pin_edge = pin_rise | pin_fall;
  assign wr_fire  = s.aw_got && s.w_got && !s.bvalid;
  assign ar_fire  = S_AXI_ARVALID && s.arready;
  assign ar_idx   = S_AXI_ARADDR[ADDR_W-1:WORD_LSB];

  // ==========================================================================
  // status-change detection
  always_comb begin
    flag_set = '0;
    if (io) begin
      flag_set[FLAG_BATT_DEAD] = pin_edge[PIN_BVD1];
    end else begin
      flag_set[FLAG_BATT_DEAD] = pin_fall[PIN_BVD1];
      flag_set[FLAG_BATT_WARN] = pin_fall[PIN_BVD2];
      flag_set[FLAG_READY]     = pin_edge[PIN_READY];
    end
    flag_set[FLAG_DETECT] = pin_edge[PIN_CD1] | pin_edge[PIN_CD2];
  end

  always_comb begin
    flag_vis = s.flags;
    flag_vis[FLAG_READY] = s.flags[FLAG_READY] & ~io;
  end

  // ==========================================================================
  // interrupt sources
  // card interrupt request is active low and only exists in I/O mode
  assign card_req = io & ~pin_level[PIN_READY];
  assign mgmt_req = ~s.ctrl[CTRL_MGMT_OFF] &
                    (|(flag_vis & s.mcfg[MCFG_EN_MSB:0]));
  // ring indicate is active low on the battery1 pin
  assign ring15   = io & s.ctrl[CTRL_RING] & s.aux[AUX_RING15] &
                    ~pin_level[PIN_BVD1];

  assign rt.card_level = s.ctrl[CTRL_LEVEL_MSB:0];
  assign rt.mgmt_level = s.mcfg[MCFG_LEVEL_MSB:MCFG_LEVEL_LSB];
  assign rt.card_req   = card_req;
  assign rt.mgmt_req   = mgmt_req;
  assign rt.ring15     = ring15;

  // ==========================================================================
  // register bus and next state
  always_comb begin
    next_s     = s;
    read_clear = 1'b0;
    if (S_AXI_BREADY && s.bvalid) begin
      next_s.bvalid = 1'b0;
    end
    if (S_AXI_RREADY && s.rvalid) begin
      next_s.rvalid = 1'b0;
    end
    if (S_AXI_AWVALID && s.awready) begin
      next_s.aw_got = 1'b1;
      next_s.waddr  = S_AXI_AWADDR[ADDR_W-1:WORD_LSB];
    end
    if (S_AXI_WVALID && s.wready) begin
      next_s.w_got = 1'b1;
      next_s.wdata = S_AXI_WDATA[REG_W-1:0];
      next_s.wstb  = S_AXI_WSTRB[0];
    end
    if (wr_fire) begin
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = RESP_OKAY;
      case (s.waddr)
        CTRL_IDX: begin
          if (s.wstb) begin
            next_s.ctrl = s.wdata;
          end
        end
        MCFG_IDX: begin
          if (s.wstb) begin
            next_s.mcfg = s.wdata;
          end
        end
        AUX_IDX: begin
          if (s.wstb) begin
            next_s.aux = s.wdata[AUX_W-1:0];
          end
        end
        // flags are read-to-clear, writes have no effect
        STATUS_IDX: next_s.bresp = RESP_OKAY;
        default:    next_s.bresp = RESP_SLVERR;
      endcase
    end
    if (ar_fire) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = RESP_OKAY;
      next_s.rdata  = '0;
      case (ar_idx)
        CTRL_IDX: next_s.rdata[REG_W-1:0] = s.ctrl;
        STATUS_IDX: begin
          next_s.rdata[FLAG_W-1:0] = flag_vis;
          read_clear = 1'b1;
        end
        MCFG_IDX: next_s.rdata[REG_W-1:0] = s.mcfg;
        AUX_IDX: begin
          next_s.rdata[AUX_W-1:0] = s.aux;
          next_s.rdata[AUX_PIN_LSB +: PIN_COUNT] = pin_level;
        end
        default: next_s.rresp = RESP_SLVERR;
      endcase
    end
    // a new edge in the clearing cycle survives the read
    next_s.flags   = (s.flags & ~{FLAG_W{read_clear}}) | flag_set;
    next_s.awready = !next_s.aw_got && !next_s.bvalid;
    next_s.wready  = !next_s.w_got && !next_s.bvalid;
    next_s.arready = !next_s.rvalid;
    next_s.irq     = rt.irq_lines;
    next_s.rst_out = ~s.ctrl[CTRL_RESET_N] ^ s.aux[AUX_ATA];
    next_s.rst_oe  = s.aux[AUX_OUT_EN];
    next_s.io_mode = io;
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      s       <= '0;
      s.ctrl  <= CTRL_RESET;
      s.mcfg  <= MCFG_RESET;
      s.aux   <= AUX_RESET;
      s.flags <= FLAG_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign S_AXI_AWREADY     = s.awready;
  assign S_AXI_WREADY      = s.wready;
  assign S_AXI_BVALID      = s.bvalid;
  assign S_AXI_BRESP       = s.bresp;
  assign S_AXI_ARREADY     = s.arready;
  assign S_AXI_RVALID      = s.rvalid;
  assign S_AXI_RRESP       = s.rresp;
  assign S_AXI_RDATA       = s.rdata;
  assign HOST_IRQ          = s.irq;
  assign CARD_RESET_OUT    = s.rst_out;
  assign CARD_RESET_OE     = s.rst_oe;
  assign IO_INTERFACE_MODE = s.io_mode;

  // ==========================================================================
  // checks
  chk_card_level_route: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    (card_req && IRQ_VALID_MASK[s.ctrl[CTRL_LEVEL_MSB:0]])
      |=> HOST_IRQ[$past(s.ctrl[CTRL_LEVEL_MSB:0])])
    else $error("card interrupt not on selected line");

  chk_reserved_quiet: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    (!(card_req && IRQ_VALID_MASK[s.ctrl[CTRL_LEVEL_MSB:0]]) &&
     !(mgmt_req && IRQ_VALID_MASK[s.mcfg[MCFG_LEVEL_MSB:MCFG_LEVEL_LSB]]) &&
     !ring15) |=> (HOST_IRQ == '0))
    else $error("host line driven without a valid source");

  chk_mgmt_suppress: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    s.ctrl[CTRL_MGMT_OFF] |=> (HOST_IRQ == '0) or $past(card_req || ring15))
    else $error("management interrupt not suppressed");

  chk_mode_follows: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    (wr_fire && s.waddr == CTRL_IDX && s.wstb)
      |=> ##1 (IO_INTERFACE_MODE == $past(s.wdata[CTRL_IO_MODE], 2)))
    else $error("interface mode did not follow control write");

  chk_reset_level: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    !SYS_RST |=> (CARD_RESET_OUT ==
         ($past(!s.ctrl[CTRL_RESET_N]) ^ $past(s.aux[AUX_ATA]))))
    else $error("card reset level wrong");

  chk_reset_float: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    !s.aux[AUX_OUT_EN] |=> !CARD_RESET_OE)
    else $error("card reset driven while outputs disabled");

  chk_ring_line: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    (io && s.ctrl[CTRL_RING] && s.aux[AUX_RING15] && !pin_level[PIN_BVD1])
      |=> HOST_IRQ[IRQ_RING_LINE])
    else $error("ring indicate not on line 15");

  chk_mgmt_enable: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    ((s.mcfg[MCFG_EN_MSB:0] == '0) && !card_req && !ring15)
      |=> (HOST_IRQ == '0))
    else $error("management interrupt without enabled flag");

  chk_dead_fall: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    (!io && pin_fall[PIN_BVD1]) |=> s.flags[FLAG_BATT_DEAD])
    else $error("battery dead edge lost");

  chk_status_any_edge: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    (io && pin_edge[PIN_BVD1]) |=> s.flags[FLAG_BATT_DEAD])
    else $error("status change edge lost in I/O mode");

  chk_warn_fall: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    (!io && pin_fall[PIN_BVD2]) |=> s.flags[FLAG_BATT_WARN])
    else $error("battery warning edge lost");

  chk_ready_io_zero: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    (ar_fire && ar_idx == STATUS_IDX && io) |=> !S_AXI_RDATA[FLAG_READY])
    else $error("ready flag visible in I/O mode");

  chk_detect_edge: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    (pin_edge[PIN_CD1] || pin_edge[PIN_CD2]) |=> s.flags[FLAG_DETECT])
    else $error("card detect edge lost");

  chk_read_clears: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    (ar_fire && ar_idx == STATUS_IDX && flag_set == '0)
      |=> (s.flags == '0) && (S_AXI_RDATA[REG_W-1:FLAG_W] == '0))
    else $error("status read did not clear flags");

  chk_mgmt_line: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    (mgmt_req && IRQ_VALID_MASK[s.mcfg[MCFG_LEVEL_MSB:MCFG_LEVEL_LSB]])
      |=> HOST_IRQ[$past(s.mcfg[MCFG_LEVEL_MSB:MCFG_LEVEL_LSB])])
    else $error("management interrupt not on selected line");

endmodule

// file: bench/siasc_card_model.sv
// card-side model driving the socket status pins
`timescale 1ns/1ps
module siasc_card_model
  import siasc_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic [PIN_COUNT-1:0] want,
  input  wire logic                 reset_out,
  input  wire logic                 reset_oe,
  output logic      [PIN_COUNT-1:0] pins,
  output logic                      reset_seen
);
  // ==========================================================
  // pin drive, one cycle behind the bench request
  always_ff @(posedge clk) begin
    pins <= want;
  end

  // released reset line sits at the card's pull-down
  assign reset_seen = reset_oe ? reset_out : 1'b0;
endmodule

// file: bench/tb_socket_irq_and_status_change.sv
// self-checking bench for the socket interrupt and status-change block
`timescale 1ns/1ps
module tb_socket_irq_and_status_change;
  import siasc_pkg::*;
  logic                 CORE_CLK, SYS_RST, S_AXI_AWVALID, S_AXI_WVALID;
  logic                 S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY;
  logic                 S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
  logic                 S_AXI_ARREADY, S_AXI_RVALID, CARD_RESET_OUT;
  logic                 CARD_RESET_OE, IO_INTERFACE_MODE, rst_seen;
  logic [ADDR_W-1:0]    S_AXI_AWADDR, S_AXI_ARADDR;
  logic [DATA_W-1:0]    S_AXI_WDATA, S_AXI_RDATA;
  logic [3:0]           S_AXI_WSTRB;
  logic [1:0]           S_AXI_BRESP, S_AXI_RRESP;
  logic [IRQ_W-1:0]     HOST_IRQ;
  logic [PIN_COUNT-1:0] want, pins;
  int                   mismatches, tests_run, ctrl, mcfg, aux, flg, r, c;
  logic [7:0]           r_tab [5] = '{8'hB7, 8'hB8, 8'h68, 8'hF8, 8'h38};

  siasc_top dut (
    .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST),
    .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
    .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
    .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID),
    .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
    .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY),
    .CARD_READY_IRQ_PIN(pins[PIN_READY]),
    .BATTERY1_STATUS_RING_PIN(pins[PIN_BVD1]),
    .BATTERY2_SPEAKER_PIN(pins[PIN_BVD2]),
    .CARD_DETECT_ONE(pins[PIN_CD1]), .CARD_DETECT_TWO(pins[PIN_CD2]),
    .HOST_IRQ(HOST_IRQ), .CARD_RESET_OUT(CARD_RESET_OUT),
    .CARD_RESET_OE(CARD_RESET_OE), .IO_INTERFACE_MODE(IO_INTERFACE_MODE)
  );

  siasc_card_model card (
    .clk(CORE_CLK), .want(want), .reset_out(CARD_RESET_OUT),
    .reset_oe(CARD_RESET_OE), .pins(pins), .reset_seen(rst_seen)
  );

  initial begin
    CORE_CLK = 1'b0;
    forever #5 CORE_CLK = ~CORE_CLK;
  end

  // ==========================================================
  // reporting
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmp_irq(input logic [15:0] e);
    tests_run++;
    if (HOST_IRQ !== e) begin
      mismatches++;
      $display("mismatch host irq expected %h seen %h", e, HOST_IRQ);
    end
  endtask

  task automatic hang();
    mismatches++;
    $display("mismatch bus answer expected handshake seen none");
    end_of_test();
  endtask

  // ==========================================================
  // behavioural model of the host lines
  function automatic logic [15:0] irq_line(input int code);
    case (code)
      3, 4, 5, 7, 9, 10, 11, 12, 14, 15: return 16'h0001 << code;
      default: return 16'h0000;
    endcase
  endfunction

  function automatic logic [15:0] exp_irq();
    logic [15:0] e;
    int          f;
    e = 16'h0000;
    f = ctrl[5] ? flg & 11 : flg;
    if (ctrl[5] && !want[PIN_READY]) e |= irq_line(ctrl & 15);
    if (!ctrl[4] && (f & mcfg & 15) != 0) e |= irq_line(mcfg >> 4);
    if (ctrl[5] && ctrl[7] && aux[1] && !want[PIN_BVD1]) e[15] = 1'b1;
    return e;
  endfunction

  // ==========================================================
  // bus and pin tasks
  task automatic put(input logic [7:0] a, input logic [7:0] d,
                     input logic [1:0] er);
    int n;
    @(posedge CORE_CLK);
    S_AXI_AWADDR  <= a;
    S_AXI_WDATA   <= {24'h000000, d};
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge CORE_CLK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      if (S_AXI_BVALID) break;
    end
    if (n == 50) hang();
    cmp("write resp", er, S_AXI_BRESP);
    case (a)
      8'h0C: ctrl = d;
      8'h14: mcfg = d;
      8'h20: aux = d;
      default: ;
    endcase
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
    int n;
    @(posedge CORE_CLK);
    S_AXI_ARADDR  <= a;
    S_AXI_ARVALID <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge CORE_CLK);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      if (S_AXI_RVALID) break;
    end
    if (n == 50) hang();
    cmp("read resp", er, S_AXI_RRESP);
    cmp("read data", ed, S_AXI_RDATA);
  endtask

  task automatic rdst();
    rdc(8'h10, ctrl[5] ? flg & 11 : flg, RESP_OKAY);
    flg = 0;
  endtask

  task automatic flip(input int i);
    logic v;
    v = !want[i];
    @(posedge CORE_CLK);
    want[i] <= v;
    case (i)
      0: if (ctrl[5] || !v) flg |= 1;
      1: if (!ctrl[5] && !v) flg |= 2;
      2: if (!ctrl[5]) flg |= 4;
      default: flg |= 8;
    endcase
    repeat (8) @(posedge CORE_CLK);
  endtask

  task automatic irqchk();
    repeat (3) @(posedge CORE_CLK);
    cmp_irq(exp_irq());
    cmp("io mode", ctrl[5], IO_INTERFACE_MODE);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    r = $urandom(40535);
    SYS_RST = 1'b1;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_ARVALID} = 3'h0;
    {S_AXI_BREADY, S_AXI_RREADY} = 2'h3;
    S_AXI_AWADDR = 8'h00;
    S_AXI_ARADDR = 8'h00;
    S_AXI_WDATA = 32'h00000000;
    S_AXI_WSTRB = 4'hF;
    want = 5'h07;
    {ctrl, mcfg, aux, flg, mismatches, tests_run} = '0;
    repeat (12) @(posedge CORE_CLK);
    SYS_RST <= 1'b0;
    repeat (6) @(posedge CORE_CLK);
    rdc(8'h0C, 0, RESP_OKAY);
    rdc(8'h14, 0, RESP_OKAY);
    rdst();
    rdc(8'h3C, 0, RESP_SLVERR);
    put(8'h3C, 8'hFF, RESP_SLVERR);
    put(8'h10, 8'hFF, RESP_OKAY);
    rdst();
    r = $urandom();
    put(8'h0C, r[7:0], RESP_OKAY);
    rdc(8'h0C, ctrl, RESP_OKAY);
    irqchk();
    put(8'h0C, 8'h60, RESP_OKAY);
    flip(PIN_READY);
    for (c = 0; c < 16; c++) begin
      put(8'h0C, 8'h60 | 8'(c), RESP_OKAY);
      irqchk();
    end
    for (c = 0; c < 2; c++) begin
      put(8'h0C, c[0] ? 8'hE0 : 8'h40, RESP_OKAY);
      rdst();
      repeat (4) begin
        repeat (3) flip(int'($urandom_range(4, 0)));
        rdst();
      end
      rdst();
    end
    put(8'h0C, 8'h40, RESP_OKAY);
    flip(PIN_CD1);
    foreach (r_tab[i]) begin
      put(8'h14, r_tab[i], RESP_OKAY);
      irqchk();
    end
    put(8'h0C, 8'h50, RESP_OKAY);
    irqchk();
    if (want[PIN_READY]) flip(PIN_READY);
    put(8'h14, 8'hFF, RESP_OKAY);
    put(8'h0C, 8'h6F, RESP_OKAY);
    irqchk();
    put(8'h14, 8'h9F, RESP_OKAY);
    irqchk();
    rdst();
    irqchk();
    put(8'h14, 8'h00, RESP_OKAY);
    put(8'h0C, 8'hE0, RESP_OKAY);
    put(8'h20, 8'h02, RESP_OKAY);
    if (want[PIN_BVD1]) flip(PIN_BVD1);
    irqchk();
    put(8'h0C, 8'h60, RESP_OKAY);
    irqchk();
    for (c = 0; c < 8; c++) begin
      put(8'h0C, c[0] ? 8'h40 : 8'h00, RESP_OKAY);
      put(8'h20, {5'h00, c[1], 1'b0, c[2]}, RESP_OKAY);
      repeat (3) @(posedge CORE_CLK);
      cmp("reset pin", c[2] & (~c[0] ^ c[1]), rst_seen);
      cmp("reset drive", c[2], CARD_RESET_OE);
    end
    end_of_test();
  end
endmodule
